// ==== encoder_pkg.sv ====
// Constants, register map and carrier types of the encoder status interface.
// Functional notes
// R01: Status bits 0-3 show functions 1-4 active.
// R02: Bit 4 flags value 1; bits 5-7 zero.
// R03: Only one measured value fetched at once.
// R04: Bit 11 set while fault acknowledge runs.
// R05: Bit 13 acknowledges cyclic absolute value request.
// R06: Higher priority use suspends absolute value.
// R07: Bit 14 set while parking encoder active.
// R08: Bit 14 clear without active parking.
// R09: Bit 15 set while encoder error active.
// R10: Fault places error code in second word.
// R11: First word counts lines times two-to-n.
// R12: Fine resolution bits come from configuration.
// R13: First word sent in every telegram cycle.
// R14: First word free-running, wraps, no modulo.
// R15: Master evaluates every wrap of first word.
// R16: First word starts at zero after power-up.
// R17: Sine/cosine lines equal signal periods per turn.
// R18: Master requests parking through control bit 14.
// R19: Command field 000 none, 001, 010, 011.
// R20: Reserved status bits 5-10, 12 read zero.
// R21: Two encoders, each an identical instance.
package encoder_pkg;

    // Clock rate and timing of the fault acknowledge.
    localparam int CLK_PERIOD_NS = 20;
    localparam int ACK_TIME_NS   = 1000;
    localparam int ACK_CYCLES    =
        (ACK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [5:0]  ACK_LAST        = 6'(ACK_CYCLES - 1);
    localparam logic [15:0] TELE_PERIOD_RST = 16'h00f9;
    localparam int          CHANNELS        = 2;

    // Register byte offsets on the APB slave.
    localparam logic [11:0] ADDR_CTRL0 = 12'h000;
    localparam logic [11:0] ADDR_CTRL1 = 12'h004;
    localparam logic [11:0] ADDR_FINE  = 12'h008;
    localparam logic [11:0] ADDR_TELE  = 12'h00c;
    localparam logic [11:0] ADDR_STAT0 = 12'h010;
    localparam logic [11:0] ADDR_POS10 = 12'h014;
    localparam logic [11:0] ADDR_POS20 = 12'h018;
    localparam logic [11:0] ADDR_STAT1 = 12'h01c;
    localparam logic [11:0] ADDR_POS11 = 12'h020;
    localparam logic [11:0] ADDR_POS21 = 12'h024;

    // Control word fields.
    localparam int CW_SEL_LO = 0;
    localparam int CW_CMD_LO = 4;
    localparam int CW_ABS    = 13;
    localparam int CW_PARK   = 14;
    localparam int CW_ACK    = 15;

    // Status word fields.
    localparam int ST_ACTIVE_LO = 0;
    localparam int ST_VALUE1    = 4;
    localparam int ST_ACK       = 11;
    localparam int ST_ABS       = 13;
    localparam int ST_PARK      = 14;
    localparam int ST_FAULT     = 15;

    // Fine resolution and value selection.
    localparam logic [3:0]  FINE_W       = 4'h8;
    localparam logic [3:0]  FINE_MAX     = 4'h8;
    localparam int          FINE_FIELD   = 4;
    localparam logic [3:0]  SEL_VALUE1   = 4'h1;
    localparam logic [31:0] ERR_ENC      = 32'h1;
    localparam logic [31:0] ERR_GET      = 32'h7;
    localparam logic [31:0] ERR_ABS      = 32'h8;

    // Command field encoding.
    typedef enum logic [2:0] {
        CMD_NONE     = 3'h0,
        CMD_ACTIVATE = 3'h1,
        CMD_READ     = 3'h2,
        CMD_CANCEL   = 3'h3
    } cmd_t;

    // Fault acknowledge sequencer.
    typedef enum logic [1:0] {
        ACK_IDLE = 2'b01,
        ACK_BUSY = 2'b10
    } ack_t;

    // Encoder pins of one channel.
    typedef struct packed {
        logic line_step;
        logic line_dir;
        logic ref_mark;
        logic fault;
    } enc_pins_t;

    // One telegram entry of one encoder.
    typedef struct packed {
        logic [15:0] status;
        logic [31:0] pos1;
        logic [31:0] pos2;
    } telegram_t;

    // State of one encoder channel.
    typedef struct packed {
        logic [15:0] ctrl;
        logic [2:0]  prev_cmd;
        logic        prev_ack;
        logic [3:0]  active;
        logic        avail;
        logic [31:0] meas;
        logic [31:0] lines;
        logic [3:0]  fine_n;
        logic        fault;
        ack_t        ack;
        logic [5:0]  ack_cnt;
        logic        park;
        logic        step_d;
        logic        mark_d;
    } chan_t;

    // Whole state of the interface.
    typedef struct packed {
        chan_t [1:0]     ch;
        logic [15:0]     tele_period;
        logic [15:0]     tele_cnt;
        telegram_t [1:0] tele;
        logic            strobe;
        logic [31:0]     prdata;
        logic            pready;
        logic            pslverr;
    } top_t;

endpackage

// ==== pin_sync.sv ====
// Two-flop synchroniser for asynchronous encoder pins.
module pin_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         srst,
    // Pins and their synchronised copy
    input  wire logic [W-1:0] pins,
    output logic      [W-1:0] synced
);

    typedef struct packed {
        logic [W-1:0] first;
        logic [W-1:0] second;
    } sync_t;

    sync_t r;
    sync_t next_r;

    // Only the second stage reads the first stage.
    always_comb begin
        next_r.first  = pins;
        next_r.second = r.first;
    end

    // Both stages clear on reset.
    always_ff @(posedge clock) begin
        if (srst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign synced = r.second;

endmodule // pin_sync

// ==== encoder_interface.sv ====
// Two-channel encoder status, position words and APB register slave.
module encoder_interface (
    // Clock and reset
    input  wire logic                          clock,
    input  wire logic                          srst,
    // APB slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [11:0]                   paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    // Encoder pins, asynchronous
    input  wire encoder_pkg::enc_pins_t [1:0]  encoder_pins,
    // Interpolator and absolute track, same clock
    input  wire logic [1:0][7:0]               fine_phase,
    input  wire logic [1:0][31:0]              abs_position,
    input  wire logic [1:0]                    abs_valid,
    // Cyclic telegram towards the master
    output encoder_pkg::telegram_t [1:0]       telegram,
    output logic                               telegram_strobe
);

    encoder_pkg::top_t r;
    encoder_pkg::top_t next_r;

    encoder_pkg::enc_pins_t [1:0] pins_s;
    logic [31:0] live_pos1 [2];
    logic [31:0] live_pos2 [2];
    logic [15:0] live_stat [2];

    // Pins of both encoders pass two flops before any use.
    pin_sync #(
        .W ($bits(encoder_pins))
    ) u_pin_sync (
        .clock  (clock),
        .srst   (srst),
        .pins   (encoder_pins),
        .synced (pins_s)
    );

    // Lines sit above the fine phase; a right shift keeps the
    // top fine bits with no multiplier.
    function automatic logic [31:0] scale(
        input logic [31:0] lines,
        input logic [7:0]  fine,
        input logic [3:0]  nbits
    );
        logic [3:0]  k;
        logic [39:0] w;
        k = (nbits > encoder_pkg::FINE_MAX) ? encoder_pkg::FINE_MAX : nbits;
        w = {lines, fine} >> (encoder_pkg::FINE_W - k);
        return w[31:0];
    endfunction

    // Live words of each encoder, one identical copy per channel.
    // R21: identical channel copies
    for (genvar c = 0; c < encoder_pkg::CHANNELS; c++) begin : g_ch
        encoder_pkg::chan_t s;
        logic [3:0] sel;
        logic       read_cmd;
        logic       read_ok;
        logic       abs_req;
        logic       abs_ack;

        assign s        = r.ch[c];
        assign sel      = s.ctrl[encoder_pkg::CW_SEL_LO +: 4];
        assign read_cmd = s.ctrl[encoder_pkg::CW_CMD_LO +: 3]
                          == encoder_pkg::CMD_READ;
        // R03: single value only
        assign read_ok  = (sel == encoder_pkg::SEL_VALUE1) && s.avail
                          && (s.active == 4'h0);
        assign abs_req  = s.ctrl[encoder_pkg::CW_ABS];
        // R05: absolute value acknowledge
        assign abs_ack  = abs_req && abs_valid[c] && !s.park && !s.fault
                          && !read_cmd;

        // R11: lines times two-to-n
        // R17: one line per sine period
        assign live_pos1[c] = scale(s.lines, fine_phase[c], s.fine_n);

        // Priority in the second word: fault code, fetched value,
        // then the absolute value.
        always_comb begin
            // R10: error code on fault
            if (s.fault) begin
                live_pos2[c] = encoder_pkg::ERR_ENC;
            end else if (read_cmd) begin
                // R03: fetch one value
                live_pos2[c] = read_ok ? s.meas : encoder_pkg::ERR_GET;
            end else if (abs_ack) begin
                live_pos2[c] = abs_position[c];
            end else if (abs_req && !s.park) begin
                live_pos2[c] = encoder_pkg::ERR_ABS;
            end else begin
                // R06: absolute value suspended
                live_pos2[c] = 32'h0;
            end
        end

        // Status word assembly; unlisted bits stay zero.
        always_comb begin
            // R20: reserved bits zero
            live_stat[c] = 16'h0;
            // R01: functions active
            live_stat[c][encoder_pkg::ST_ACTIVE_LO +: 4] = s.active;
            // R02: value one available
            live_stat[c][encoder_pkg::ST_VALUE1] = s.avail;
            // R04: acknowledge in progress
            live_stat[c][encoder_pkg::ST_ACK] =
                (s.ack == encoder_pkg::ACK_BUSY);
            live_stat[c][encoder_pkg::ST_ABS] = abs_ack;
            // R07: parking shows
            // R08: clear when not parked
            live_stat[c][encoder_pkg::ST_PARK] = s.park;
            // R09: encoder error flag
            live_stat[c][encoder_pkg::ST_FAULT] = s.fault;
        end
    end

    // Next-state logic for channels, telegram timer and APB slave.
    always_comb begin
        logic [2:0]  cmd;
        logic [3:0]  sel;
        logic        cmd_new;
        logic        step_s;
        logic        mark_s;
        logic        fault_s;
        logic        access;
        logic        mapped;
        logic        writable;
        logic [31:0] rd;
        cmd      = 3'h0;
        sel      = 4'h0;
        cmd_new  = 1'b0;
        step_s   = 1'b0;
        mark_s   = 1'b0;
        fault_s  = 1'b0;
        access   = 1'b0;
        mapped   = 1'b0;
        writable = 1'b0;
        rd       = 32'h0;
        next_r   = r;

        for (int c = 0; c < encoder_pkg::CHANNELS; c++) begin
            cmd     = r.ch[c].ctrl[encoder_pkg::CW_CMD_LO +: 3];
            sel     = r.ch[c].ctrl[encoder_pkg::CW_SEL_LO +: 4];
            cmd_new = cmd != r.ch[c].prev_cmd;
            step_s  = pins_s[c].line_step;
            mark_s  = pins_s[c].ref_mark;
            fault_s = pins_s[c].fault;
            next_r.ch[c].prev_cmd = cmd;
            next_r.ch[c].step_d   = step_s;
            next_r.ch[c].mark_d   = mark_s;
            next_r.ch[c].prev_ack = r.ch[c].ctrl[encoder_pkg::CW_ACK];

            // R18: parking follows the request bit
            next_r.ch[c].park = r.ch[c].ctrl[encoder_pkg::CW_PARK];

            // R14: free-running count, wraps silently
            // R15: master evaluates wraps
            if (step_s && !r.ch[c].step_d && !r.ch[c].park) begin
                if (pins_s[c].line_dir) begin
                    next_r.ch[c].lines = r.ch[c].lines + 32'h1;
                end else begin
                    next_r.ch[c].lines = r.ch[c].lines - 32'h1;
                end
            end

            // R19: command decode on a change of the field
            if (cmd_new) begin
                case (encoder_pkg::cmd_t'(cmd))
                    encoder_pkg::CMD_ACTIVATE: begin
                        if (!r.ch[c].fault && !r.ch[c].park) begin
                            next_r.ch[c].active = r.ch[c].active | sel;
                            if (sel[0]) begin
                                next_r.ch[c].avail = 1'b0;
                            end
                        end
                    end
                    encoder_pkg::CMD_CANCEL: begin
                        next_r.ch[c].active = r.ch[c].active & ~sel;
                        if (sel[0]) begin
                            next_r.ch[c].avail = 1'b0;
                        end
                    end
                    default: begin
                    end
                endcase
            end

            // A parked encoder is switched off, so no function runs.
            if (r.ch[c].park) begin
                next_r.ch[c].active = 4'h0;
            end

            // R01: function one ends at the reference mark edge
            // R02: capture sets value one, winning over a clear
            if (mark_s && !r.ch[c].mark_d && r.ch[c].active[0]
                && !r.ch[c].park) begin
                next_r.ch[c].meas      = live_pos1[c];
                next_r.ch[c].active[0] = 1'b0;
                next_r.ch[c].avail     = 1'b1;
            end

            // R04: acknowledge sequencer started by the request edge
            case (r.ch[c].ack)
                encoder_pkg::ACK_IDLE: begin
                    next_r.ch[c].ack_cnt = 6'h00;
                    if (r.ch[c].ctrl[encoder_pkg::CW_ACK]
                        && !r.ch[c].prev_ack) begin
                        next_r.ch[c].ack = encoder_pkg::ACK_BUSY;
                    end
                end
                encoder_pkg::ACK_BUSY: begin
                    next_r.ch[c].ack_cnt = r.ch[c].ack_cnt + 6'h01;
                    if (r.ch[c].ack_cnt == encoder_pkg::ACK_LAST) begin
                        next_r.ch[c].ack   = encoder_pkg::ACK_IDLE;
                        next_r.ch[c].fault = 1'b0;
                    end
                end
                default: begin
                    next_r.ch[c].ack = encoder_pkg::ACK_IDLE;
                end
            endcase

            // R09: a live fault sets the flag and beats the clear
            if (fault_s) begin
                next_r.ch[c].fault = 1'b1;
            end
        end

        // R13: snapshot every telegram cycle
        next_r.strobe = 1'b0;
        if (r.tele_cnt >= r.tele_period) begin
            next_r.tele_cnt = 16'h0;
            next_r.strobe   = 1'b1;
            for (int c = 0; c < encoder_pkg::CHANNELS; c++) begin
                next_r.tele[c].status = live_stat[c];
                next_r.tele[c].pos1   = live_pos1[c];
                next_r.tele[c].pos2   = live_pos2[c];
            end
        end else begin
            next_r.tele_cnt = r.tele_cnt + 16'h1;
        end

        // Address decode; status and position words are read-only.
        case (paddr)
            encoder_pkg::ADDR_CTRL0: begin
                rd       = {16'h0, r.ch[0].ctrl};
                mapped   = 1'b1;
                writable = 1'b1;
            end
            encoder_pkg::ADDR_CTRL1: begin
                rd       = {16'h0, r.ch[1].ctrl};
                mapped   = 1'b1;
                writable = 1'b1;
            end
            encoder_pkg::ADDR_FINE: begin
                rd       = {24'h0, r.ch[1].fine_n, r.ch[0].fine_n};
                mapped   = 1'b1;
                writable = 1'b1;
            end
            encoder_pkg::ADDR_TELE: begin
                rd       = {16'h0, r.tele_period};
                mapped   = 1'b1;
                writable = 1'b1;
            end
            encoder_pkg::ADDR_STAT0: begin
                rd     = {16'h0, r.tele[0].status};
                mapped = 1'b1;
            end
            encoder_pkg::ADDR_POS10: begin
                rd     = r.tele[0].pos1;
                mapped = 1'b1;
            end
            encoder_pkg::ADDR_POS20: begin
                rd     = r.tele[0].pos2;
                mapped = 1'b1;
            end
            encoder_pkg::ADDR_STAT1: begin
                rd     = {16'h0, r.tele[1].status};
                mapped = 1'b1;
            end
            encoder_pkg::ADDR_POS11: begin
                rd     = r.tele[1].pos1;
                mapped = 1'b1;
            end
            encoder_pkg::ADDR_POS21: begin
                rd     = r.tele[1].pos2;
                mapped = 1'b1;
            end
            default: begin
                rd = 32'h0;
            end
        endcase

        // Answer is built in setup so that outputs come from flops
        // with no wait state.
        next_r.pready  = 1'b0;
        next_r.pslverr = 1'b0;
        if (psel && !penable) begin
            next_r.pready  = 1'b1;
            next_r.prdata  = pwrite ? 32'h0 : rd;
            next_r.pslverr = !mapped || (pwrite && !writable);
        end

        // Writes take effect at the completing access edge only.
        access = psel && penable && r.pready;
        if (access && pwrite && writable) begin
            case (paddr)
                encoder_pkg::ADDR_CTRL0: begin
                    next_r.ch[0].ctrl = pwdata[15:0];
                end
                encoder_pkg::ADDR_CTRL1: begin
                    next_r.ch[1].ctrl = pwdata[15:0];
                end
                encoder_pkg::ADDR_FINE: begin
                    // R12: fine bits from configuration
                    next_r.ch[0].fine_n = pwdata[0 +: encoder_pkg::FINE_FIELD];
                    next_r.ch[1].fine_n =
                        pwdata[encoder_pkg::FINE_FIELD +: encoder_pkg::FINE_FIELD];
                end
                encoder_pkg::ADDR_TELE: begin
                    next_r.tele_period = pwdata[15:0];
                end
                default: begin
                end
            endcase
        end
    end

    // One register stage for all state.
    always_ff @(posedge clock) begin
        if (srst) begin
            // R16: position words start at zero
            r             <= '0;
            r.ch[0].ack   <= encoder_pkg::ACK_IDLE;
            r.ch[1].ack   <= encoder_pkg::ACK_IDLE;
            r.tele_period <= encoder_pkg::TELE_PERIOD_RST;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from state flops.
    assign prdata          = r.prdata;
    assign pready          = r.pready;
    assign pslverr         = r.pslverr;
    assign telegram        = r.tele;
    assign telegram_strobe = r.strobe;

endmodule // encoder_interface

// ==== encoder_check_sva.sv ====
// Port-level assertions for the encoder status interface.
module encoder_check (
    // Clock and reset
    input wire logic                         clock,
    input wire logic                         srst,
    // APB handshake
    input wire logic                         psel,
    input wire logic                         penable,
    input wire logic                         pready,
    input wire logic                         pslverr,
    // Telegram
    input wire encoder_pkg::telegram_t [1:0] telegram,
    input wire logic                         telegram_strobe
);
    // All checks share the one clock and drop out during reset.
    default clocking @(posedge clock); endclocking
    default disable iff (srst);

    reserved_zero_a: assert property (
        telegram[0].status[10:5] == 6'h00 && !telegram[0].status[12])
        else $error("reserved bits set, enc one");
    enc_two_reserved_a: assert property (
        telegram[1].status[10:5] == 6'h00 && !telegram[1].status[12])
        else $error("reserved bits set, enc two");
    fault_code_a: assert property (
        telegram[0].status[15] |-> telegram[0].pos2 == 32'h1)
        else $error("fault without code");
    abs_suspend_a: assert property (
        telegram[0].status[13] |-> !telegram[0].status[15]
            && !telegram[0].status[14])
        else $error("abs ack while suspended");
    pos_start_a: assert property (
        $fell(srst) |-> telegram[0].pos1 == 32'h0 && telegram[1].pos1 == 32'h0)
        else $error("position not zero");
    telegram_hold_a: assert property (
        !$stable(telegram) |-> telegram_strobe)
        else $error("change without strobe");
    strobe_pulse_a: assert property (
        telegram_strobe |=> !telegram_strobe [*8])
        else $error("strobe too close");
    apb_answer_a: assert property (
        psel && !penable |=> pready)
        else $error("late ready");
    ready_pulse_a: assert property (
        pready |=> !pready)
        else $error("ready too long");
    err_with_ready_a: assert property (
        pslverr |-> pready)
        else $error("error without ready");
endmodule // encoder_check

bind encoder_interface encoder_check encoder_check_i (
    .clock(clock), .srst(srst), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .telegram(telegram),
    .telegram_strobe(telegram_strobe));

// ==== telegram_reader.sv ====
// Master controller model that tracks the wrapping position word.
module telegram_reader (
    // Clock and reset
    input  wire logic          clock,
    input  wire logic          srst,
    // Telegram entry of encoder one
    input  wire logic          telegram_strobe,
    input  wire logic [31:0]   pos1,
    // Extended position seen by the master
    output logic signed [63:0] track
);
    logic [31:0] last;

    // a signed delta survives any wrap.
    always_ff @(posedge clock) begin
        if (srst) begin
            last  <= 32'h0;
            track <= 64'sh0;
        end else if (telegram_strobe) begin
            last  <= pos1;
            track <= track + $signed(pos1 - last);
        end
    end
endmodule // telegram_reader

// ==== encoder_interface_bench.sv ====
// Self-checking testbench for the encoder status interface.
module encoder_interface_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic                         clock = 1'b0;
    logic                         srst = 1'b1;
    logic                         psel = 1'b0;
    logic                         penable = 1'b0;
    logic                         pwrite = 1'b0;
    logic [11:0]                  paddr = 12'h000;
    logic [31:0]                  pwdata = 32'h0;
    logic [31:0]                  prdata;
    logic                         pready;
    logic                         pslverr;
    encoder_pkg::enc_pins_t [1:0] pins = '0;
    logic [1:0][7:0]              fine_phase = {8'h80, 8'h80};
    logic [1:0][31:0]             abs_position = {32'h0, 32'h1234_5678};
    logic [1:0]                   abs_valid = 2'h1;
    encoder_pkg::telegram_t [1:0] telegram;
    logic                         telegram_strobe;
    logic signed [63:0]           track;
    logic [31:0]                  rdata;
    logic                         rerr;
    int                           miscompares = 0;
    int                           samples_checked = 0;

    encoder_interface encoder_interface_i (
        .clock(clock), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .encoder_pins(pins),
        .fine_phase(fine_phase), .abs_position(abs_position),
        .abs_valid(abs_valid), .telegram(telegram),
        .telegram_strobe(telegram_strobe));

    telegram_reader telegram_reader_i (
        .clock(clock), .srst(srst), .telegram_strobe(telegram_strobe),
        .pos1(telegram[0].pos1), .track(track));

    // A 20 ns clock.
    initial begin
        forever #10 clock = ~clock;
    end

    task automatic end_of_test();
        $display("checked %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_flag(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: error flag %b", $time, got);
        end
    endtask

    // One APB transfer, held until ready, then one idle cycle.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    // Reads a register, compares masked bits.
    task automatic rd(input logic [11:0] a, input logic [31:0] m,
                      input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check_word(rdata & m, exp);
    endtask

    // Waits for n telegram strobes, each bounded.
    task automatic frames(input int n);
        int k;
        repeat (n) begin
            k = 0;
            do begin
                @(posedge clock);
                k++;
            end while (telegram_strobe !== 1'b1 && k < 400);
            check_flag(telegram_strobe, 1'b1);
        end
    endtask

    // One encoder line, long enough for the synchroniser.
    task automatic step(input int c, input logic up);
        pins[c].line_dir <= up;
        pins[c].line_step <= 1'b1;
        repeat (4) @(posedge clock);
        pins[c].line_step <= 1'b0;
        repeat (4) @(posedge clock);
    endtask

    // Watchdog far beyond the few hundred cycles the run needs.
    initial begin
        #100us;
        miscompares++;
        end_of_test();
    end

    initial begin
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        check_word(telegram[0].pos1, 32'h0);
        rd(encoder_pkg::ADDR_TELE, 32'hffffffff, 32'hf9);
        apb(1'b0, 12'h028, 32'h0);
        check_flag(rerr, 1'b1);
        apb(1'b1, encoder_pkg::ADDR_STAT0, 32'hffffffff);
        check_flag(rerr, 1'b1);
        apb(1'b1, encoder_pkg::ADDR_TELE, 32'h9);
        apb(1'b1, encoder_pkg::ADDR_FINE, 32'h84);
        repeat (3) step(0, 1'b1);
        step(1, 1'b1);
        frames(2);
        rd(encoder_pkg::ADDR_POS10, 32'hffffffff, 32'h38);
        rd(encoder_pkg::ADDR_POS11, 32'hffffffff, 32'h180);
        apb(1'b1, encoder_pkg::ADDR_CTRL0, 32'h11);
        frames(2);
        rd(encoder_pkg::ADDR_STAT0, 32'hff, 32'h1);
        pins[0].ref_mark <= 1'b1;
        repeat (4) @(posedge clock);
        pins[0].ref_mark <= 1'b0;
        frames(2);
        rd(encoder_pkg::ADDR_STAT0, 32'hff, 32'h10);
        apb(1'b1, encoder_pkg::ADDR_CTRL0, 32'h21);
        frames(2);
        rd(encoder_pkg::ADDR_POS20, 32'hffffffff, 32'h38);
        apb(1'b1, encoder_pkg::ADDR_CTRL0, 32'h23);
        frames(2);
        rd(encoder_pkg::ADDR_POS20, 32'hffffffff, 32'h7);
        apb(1'b1, encoder_pkg::ADDR_CTRL0, 32'h2000);
        frames(2);
        rd(encoder_pkg::ADDR_STAT0, 32'h6000, 32'h2000);
        rd(encoder_pkg::ADDR_POS20, 32'hffffffff, 32'h1234_5678);
        abs_valid <= 2'h0;
        frames(2);
        rd(encoder_pkg::ADDR_POS20, 32'hffffffff, 32'h8);
        apb(1'b1, encoder_pkg::ADDR_CTRL0, 32'h6000);
        frames(2);
        rd(encoder_pkg::ADDR_STAT0, 32'h6000, 32'h4000);
        apb(1'b1, encoder_pkg::ADDR_CTRL0, 32'h0);
        frames(2);
        rd(encoder_pkg::ADDR_STAT0, 32'h4000, 32'h0);
        repeat (4) step(0, 1'b0);
        frames(2);
        rd(encoder_pkg::ADDR_POS10, 32'hffffffff, 32'hfffffff8);
        check_word(track[63:32], 32'hffffffff);
        check_word(track[31:0], 32'hfffffff8);
        pins[0].fault <= 1'b1;
        frames(2);
        rd(encoder_pkg::ADDR_STAT0, 32'h8000, 32'h8000);
        rd(encoder_pkg::ADDR_POS20, 32'hffffffff, 32'h1);
        pins[0].fault <= 1'b0;
        apb(1'b1, encoder_pkg::ADDR_CTRL0, 32'h8000);
        frames(2);
        rd(encoder_pkg::ADDR_STAT0, 32'h800, 32'h800);
        repeat (60) @(posedge clock);
        frames(2);
        rd(encoder_pkg::ADDR_STAT0, 32'h8800, 32'h0);
        end_of_test();
    end
endmodule // encoder_interface_bench
